// ==== inc/dtw_cfg.svh ====
// Constants for the tuning word path: offsets, fields, resets, timing
// What this block does
// - Phase lock indication sets when the level rises above +1024, holds between marks.
// - Phase lock indication clears when the level falls below -1024.
// - Free-run or holdover forces both lock indications to unlocked.
// - During switchover the lock detectors hold their prior state.
// - Frequency detector uses the same level mechanism on period difference magnitude.
// - Frequency threshold is unsigned 24-bit picoseconds against absolute period difference.
// - Accumulator adds the 48-bit tuning word every cycle, wrapping modulo 2^48.
// - A 16-bit phase offset is added to the accumulator top bits.
// - Free-run takes the tuning word from the free-running register.
// - Closed loop takes the tuning word from the loop filter.
// - Holdover takes the stored history average; with none, the last closed word if fallback set, else the free-running register.
// - Applied word always limited between 24-bit upper and lower clamps.
// - Clamp limits reset to zero and full scale, so no effect.
// - History averages loop words over a 24-bit millisecond interval, minimum one.
// - Each interval average stored in read-only history register, independent of earlier.
// - Each stored average emits a strobe; the history-updated status bit is set by it only while the mask bit is one.
// - New reference restarts accumulation; history cleared unless persistent bit set.
// - Software clear bit or clear pin erases the stored history.
// - With no history, first value is stored only when the timer expires.
// - After clear, K adds intermediate averages at interval/2^K, doubling, first interval only.
// - After the first interval, averages only at full-interval boundaries.
// - Each sample adds fill if magnitude within threshold, else subtracts drain.
// - Level spans -2048 to +2048 and saturates.
`ifndef DTW_CFG_SVH
`define DTW_CFG_SVH
`define DTW_A_DAC_CUR 12'h213
`define DTW_A_FREE_LO 12'h300
`define DTW_A_FREE_HI 12'h301
`define DTW_A_CLAMP_LO 12'h307
`define DTW_A_CLAMP_HI 12'h308
`define DTW_A_PHASE_OFS 12'h30d
`define DTW_A_AVG_INT 12'h318
`define DTW_A_HIST_CTL 12'h31b
`define DTW_A_HIST_LO 12'hd14
`define DTW_A_HIST_HI 12'hd15
`define DTW_A_LOCK_CFG 12'h320
`define DTW_A_FREQ_THR 12'h321
`define DTW_A_STATUS 12'h322
`define DTW_A_IRQ_MASK 12'h323
`define DTW_A_CMD 12'h324
`define DTW_F_K_LSB 0
`define DTW_F_PERSIST 3
`define DTW_F_FALLBACK 4
`define DTW_F_CLEAR 2
`define DTW_LVL_HI 13'sd1024
`define DTW_LVL_LO -13'sd1024
`define DTW_LVL_MAX 13'sd2048
`define DTW_LVL_MIN -13'sd2048
`define DTW_CLAMP_LO_RST 24'h000000
`define DTW_CLAMP_HI_RST 24'hffffff
`define DTW_AVG_INT_RST 24'h000001
`define DTW_MS_NS 1000000
`define DTW_CLK_NS 25
`define DTW_MS_CYC (`DTW_MS_NS / `DTW_CLK_NS)
`endif

// ==== inc/dtw_pkg.sv ====
// Types for the tuning word path
package dtw_pkg;
    typedef enum logic [1:0] {dtw_free_run, dtw_closed, dtw_holdover} dtw_mode_t;
endpackage

// ==== src/dtw_path.sv ====
// Lock detectors, tuning word select, clamp, history averager and phase accumulator
//
// The strobed register port was chosen for this implementation.
`include "dtw_cfg.svh"
module dtw_path import dtw_pkg::*; #(
    parameter int MS_CYCLES = `DTW_MS_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [1:0] loop_mode,
    input wire logic switchover,
    input wire logic new_ref,
    input wire logic hist_clear_pin,
    input wire logic [47:0] loop_word,
    input wire logic phase_valid,
    input wire logic [31:0] phase_err,
    input wire logic freq_valid,
    input wire logic [31:0] period_diff,
    output logic phase_locked,
    output logic freq_locked,
    output logic history_strobe,
    output logic history_irq,
    output logic [47:0] applied_word,
    output logic [15:0] synth_phase
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] dac_full_scale_current;
    logic [47:0] free_running_tuning_word;
    logic [47:0] frequency_clamp_limits;
    logic [15:0] open_loop_phase_offset;
    logic [23:0] history_average_interval;
    logic [7:0] history_control;
    logic [47:0] averaged_tuning_word;
    logic [15:0] phase_thr;
    logic [7:0] fill_rate;
    logic [7:0] drain_rate;
    logic [23:0] freq_thr;
    logic hist_updated;
    logic hist_mask;
    logic sw_clear;
    logic history_valid;
    logic [47:0] last_closed;
    logic pin_s1;
    logic pin_s2;

    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? 32'(-v) : v;
    endfunction

    // Saturating level step
    function automatic logic signed [12:0] lvl_step(input logic signed [12:0] l,
            input logic ok, input logic [7:0] f, input logic [7:0] d);
        logic signed [13:0] n;
        n = ok ? 14'(l) + 14'(f) : 14'(l) - 14'(d);
        if (n > 14'(`DTW_LVL_MAX))
            lvl_step = `DTW_LVL_MAX;
        else if (n < 14'(`DTW_LVL_MIN))
            lvl_step = `DTW_LVL_MIN;
        else
            lvl_step = 13'(n);
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dac_full_scale_current <= 16'h0000;
            free_running_tuning_word <= 48'h0;
            frequency_clamp_limits <= {`DTW_CLAMP_HI_RST, `DTW_CLAMP_LO_RST};
            open_loop_phase_offset <= 16'h0000;
            history_average_interval <= `DTW_AVG_INT_RST;
            history_control <= 8'h00;
            phase_thr <= 16'h0000;
            fill_rate <= 8'h01;
            drain_rate <= 8'h01;
            freq_thr <= 24'h000000;
            hist_mask <= 1'b0;
        end else if (wr) begin
            case (addr)
                `DTW_A_DAC_CUR: dac_full_scale_current <= wdata[15:0];
                `DTW_A_FREE_LO: free_running_tuning_word[31:0] <= wdata;
                `DTW_A_FREE_HI: free_running_tuning_word[47:32] <= wdata[15:0];
                `DTW_A_CLAMP_LO: frequency_clamp_limits[23:0] <= wdata[23:0];
                `DTW_A_CLAMP_HI: frequency_clamp_limits[47:24] <= wdata[23:0];
                `DTW_A_PHASE_OFS: open_loop_phase_offset <= wdata[15:0];
                `DTW_A_AVG_INT: history_average_interval <= wdata[23:0];
                `DTW_A_HIST_CTL: history_control <= wdata[7:0];
                `DTW_A_LOCK_CFG: begin
                    phase_thr <= wdata[15:0];
                    fill_rate <= wdata[23:16];
                    drain_rate <= wdata[31:24];
                end
                `DTW_A_FREQ_THR: freq_thr <= wdata[23:0];
                `DTW_A_IRQ_MASK: hist_mask <= wdata[0];
                default: ;
            endcase
        end
    end

    // Command bit self-clears: a one-cycle pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            sw_clear <= 1'b0;
        else
            sw_clear <= wr && addr == `DTW_A_CMD && wdata[`DTW_F_CLEAR];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= hist_clear_pin;
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                `DTW_A_DAC_CUR: rdata <= {16'h0, dac_full_scale_current};
                `DTW_A_FREE_LO: rdata <= free_running_tuning_word[31:0];
                `DTW_A_FREE_HI: rdata <= {16'h0, free_running_tuning_word[47:32]};
                `DTW_A_CLAMP_LO: rdata <= {8'h0, frequency_clamp_limits[23:0]};
                `DTW_A_CLAMP_HI: rdata <= {8'h0, frequency_clamp_limits[47:24]};
                `DTW_A_PHASE_OFS: rdata <= {16'h0, open_loop_phase_offset};
                `DTW_A_AVG_INT: rdata <= {8'h0, history_average_interval};
                `DTW_A_HIST_CTL: rdata <= {24'h0, history_control};
                `DTW_A_HIST_LO: rdata <= averaged_tuning_word[31:0];
                `DTW_A_HIST_HI: rdata <= {16'h0, averaged_tuning_word[47:32]};
                `DTW_A_LOCK_CFG: rdata <= {drain_rate, fill_rate, phase_thr};
                `DTW_A_FREQ_THR: rdata <= {8'h0, freq_thr};
                `DTW_A_STATUS: rdata <= {28'h0, history_valid, hist_updated,
                                         freq_locked, phase_locked};
                `DTW_A_IRQ_MASK: rdata <= {31'h0, hist_mask};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detectors
    logic signed [12:0] phase_lvl;
    logic signed [12:0] freq_lvl;
    logic open_loop;
    assign open_loop = loop_mode != dtw_closed;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_lvl <= `DTW_LVL_MIN;
            phase_locked <= 1'b0;
        end else if (switchover) begin
            phase_locked <= phase_locked;
        end else if (open_loop) begin
            phase_locked <= 1'b0;
            phase_lvl <= `DTW_LVL_MIN;
        end else begin
            if (phase_valid)
                phase_lvl <= lvl_step(phase_lvl, mag(phase_err) <= {16'h0, phase_thr},
                                      fill_rate, drain_rate);
            if (phase_lvl > `DTW_LVL_HI)
                phase_locked <= 1'b1;
            else if (phase_lvl < `DTW_LVL_LO)
                phase_locked <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            freq_lvl <= `DTW_LVL_MIN;
            freq_locked <= 1'b0;
        end else if (switchover) begin
            freq_locked <= freq_locked;
        end else if (open_loop) begin
            freq_locked <= 1'b0;
            freq_lvl <= `DTW_LVL_MIN;
        end else begin
            if (freq_valid)
                freq_lvl <= lvl_step(freq_lvl, mag(period_diff) <= {8'h0, freq_thr},
                                     fill_rate, drain_rate);
            if (freq_lvl > `DTW_LVL_HI)
                freq_locked <= 1'b1;
            else if (freq_lvl < `DTW_LVL_LO)
                freq_locked <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tuning word selection and clamp
    logic [47:0] sel_word;
    logic [47:0] next_applied;
    always_comb begin
        case (loop_mode)
            dtw_closed: sel_word = loop_word;
            dtw_holdover: begin
                if (history_valid)
                    sel_word = averaged_tuning_word;
                else if (history_control[`DTW_F_FALLBACK])
                    sel_word = last_closed;
                else
                    sel_word = free_running_tuning_word;
            end
            default: sel_word = free_running_tuning_word;
        endcase
        if (sel_word[47:24] > frequency_clamp_limits[47:24])
            next_applied = {frequency_clamp_limits[47:24], 24'h0};
        else if (sel_word[47:24] < frequency_clamp_limits[23:0])
            next_applied = {frequency_clamp_limits[23:0], 24'h0};
        else
            next_applied = sel_word;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            applied_word <= 48'h0;
            last_closed <= 48'h0;
        end else begin
            applied_word <= next_applied;
            if (loop_mode == dtw_closed)
                last_closed <= next_applied;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase accumulator
    logic [47:0] acc;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 48'h0;
            synth_phase <= 16'h0;
        end else begin
            acc <= acc + applied_word;
            synth_phase <= acc[47:32] + open_loop_phase_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // History averager
    // Sum wide enough for 2^40 samples; longer intervals lose accuracy only
    logic [87:0] sum;
    logic [39:0] nsamp;
    logic [15:0] ms_cnt;
    logic [26:0] ms_total;
    logic [2:0] k_left;
    logic first_int;
    logic restart;
    logic wipe;
    logic [26:0] target;
    logic tick;
    assign wipe = sw_clear || pin_s2
        || (new_ref && !history_control[`DTW_F_PERSIST]);
    assign restart = wipe || new_ref;
    // Intermediate boundary: interval >> k_left, full interval when zero
    assign target = first_int ? ({3'h0, history_average_interval} >> k_left)
                              : {3'h0, history_average_interval};
    assign tick = ms_cnt == 16'(MS_CYCLES - 1);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sum <= 88'h0;
            nsamp <= 40'h0;
            ms_cnt <= 16'h0;
            ms_total <= 27'h0;
            k_left <= 3'h0;
            first_int <= 1'b1;
            history_valid <= 1'b0;
            averaged_tuning_word <= 48'h0;
            history_strobe <= 1'b0;
        end else begin
            history_strobe <= 1'b0;
            if (restart) begin
                sum <= 88'h0;
                nsamp <= 40'h0;
                ms_cnt <= 16'h0;
                ms_total <= 27'h0;
                if (wipe) begin
                    history_valid <= 1'b0;
                    first_int <= 1'b1;
                    k_left <= history_control[2:0];
                end
            end else if (loop_mode == dtw_closed) begin
                ms_cnt <= tick ? 16'h0 : ms_cnt + 16'h1;
                if (tick && ms_total + 27'h1 >= target) begin
                    averaged_tuning_word <= 48'((sum + 88'(loop_word))
                                               / 88'(nsamp + 40'h1));
                    history_valid <= 1'b1;
                    history_strobe <= 1'b1;
                    sum <= 88'h0;
                    nsamp <= 40'h0;
                    if (k_left != 3'h0 && first_int) begin
                        k_left <= k_left - 3'h1;
                        ms_total <= ms_total + 27'h1;
                    end else begin
                        first_int <= 1'b0;
                        ms_total <= 27'h0;
                    end
                end else begin
                    sum <= sum + 88'(loop_word);
                    nsamp <= nsamp + 40'h1;
                    if (tick)
                        ms_total <= ms_total + 27'h1;
                end
            end
        end
    end

    // Every average, intermediate or full, restarts the sum so each covers only the span since the last one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hist_updated <= 1'b0;
            history_irq <= 1'b0;
        end else begin
            if (history_strobe && hist_mask)
                hist_updated <= 1'b1;
            else if (wr && addr == `DTW_A_STATUS && wdata[2])
                hist_updated <= 1'b0;
            history_irq <= hist_updated;
        end
    end

endmodule // dtw_path

// ==== tb/dtw_path_chk.sv ====
// Port checker for the tuning word path
`include "dtw_cfg.svh"
module dtw_path_chk import dtw_pkg::*; #(
    parameter int MS_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic [1:0] loop_mode,
    input wire logic switchover,
    input wire logic [47:0] loop_word,
    input wire logic phase_valid,
    input wire logic phase_locked,
    input wire logic freq_locked,
    input wire logic history_strobe,
    input wire logic history_irq,
    input wire logic [47:0] applied_word,
    input wire logic [15:0] synth_phase
);
logic [23:0] lim_lo;
logic [23:0] lim_hi;
logic [1:0] since_lim;
logic irq_en;
////////////////////////////////////////////////////////////////////////////////
// Shadow of clamp and mask registers
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        lim_lo <= `DTW_CLAMP_LO_RST;
        lim_hi <= `DTW_CLAMP_HI_RST;
        irq_en <= 1'b0;
    end else if (wr) begin
        if (addr == `DTW_A_CLAMP_LO) lim_lo <= wdata[23:0];
        if (addr == `DTW_A_CLAMP_HI) lim_hi <= wdata[23:0];
        if (addr == `DTW_A_IRQ_MASK) irq_en <= wdata[0];
    end
end
// New limits need a few cycles to reach the applied word
always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) since_lim <= 2'h3;
    else if (wr && (addr == `DTW_A_CLAMP_LO || addr == `DTW_A_CLAMP_HI)) since_lim <= 2'h0;
    else if (since_lim != 2'h3) since_lim <= since_lim + 2'h1;
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
sequence s_open_mode;
    (loop_mode != 2'h1 && !switchover) [*2];
endsequence
sequence s_closed_steady;
    (loop_mode == 2'h1 && $stable(loop_word) && lim_lo == 24'h0 && lim_hi == 24'hffffff) [*2];
endsequence
sequence s_word_steady;
    (!wr && $stable(applied_word) && applied_word[31:0] == 32'h0) [*4];
endsequence
property p_open_unlock;
    s_open_mode |-> !phase_locked && !freq_locked;
endproperty
a_open_unlock: assert property (p_open_unlock) else $error("lock shown in open loop");
property p_switch_hold;
    switchover ##1 switchover |-> $stable(phase_locked) && $stable(freq_locked);
endproperty
a_switch_hold: assert property (p_switch_hold) else $error("lock moved in switchover");
property p_lock_cause;
    $rose(phase_locked) |-> $past(phase_valid) || $past(phase_valid, 2);
endproperty
a_lock_cause: assert property (p_lock_cause) else $error("lock without sample");
property p_strobe_pulse;
    history_strobe |=> !history_strobe;
endproperty
a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
property p_irq_set;
    history_strobe && irq_en |-> ##[1:2] history_irq;
endproperty
a_irq_set: assert property (p_irq_set) else $error("status not raised");
property p_clamp;
    since_lim == 2'h3 |-> applied_word[47:24] >= lim_lo && applied_word[47:24] <= lim_hi;
endproperty
a_clamp: assert property (p_clamp) else $error("word outside limits");
property p_closed_pass;
    s_closed_steady |-> applied_word == loop_word;
endproperty
a_closed_pass: assert property (p_closed_pass) else $error("loop word not applied");
property p_accum;
    s_word_steady |-> synth_phase == 16'($past(synth_phase) + applied_word[47:32]);
endproperty
a_accum: assert property (p_accum) else $error("phase step wrong");
endmodule // dtw_path_chk
bind dtw_path dtw_path_chk #(.MS_CYCLES(MS_CYCLES)) u_dtw_path_chk (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .loop_mode(loop_mode), .switchover(switchover), .loop_word(loop_word),
    .phase_valid(phase_valid), .phase_locked(phase_locked), .freq_locked(freq_locked),
    .history_strobe(history_strobe), .history_irq(history_irq),
    .applied_word(applied_word), .synth_phase(synth_phase)
);

// ==== tb/dtw_path_bench.sv ====
// Self-checking bench for the tuning word path
`include "dtw_cfg.svh"
module dtw_path_bench import dtw_pkg::*;;
timeunit 1ns;
timeprecision 1ps;
typedef struct {logic [1:0] mode; logic [23:0] lo, hi; logic [47:0] lw, exp;} dtw_row_t;
localparam logic [47:0] FREE = 48'h1234_5678_9abc;
localparam logic [47:0] LW = 48'h0a0a_0000_0000;
logic mclk = 1'b0;
logic rst_n = 1'b0;
logic [11:0] addr = 12'h000;
logic [31:0] wdata = 32'h0, phase_err = 32'h0, period_diff = 32'h0, rdata, rv;
logic wr = 1'b0, rd = 1'b0, switchover = 1'b0, new_ref = 1'b0, hist_clear_pin = 1'b0;
logic phase_valid = 1'b0, freq_valid = 1'b0;
logic [1:0] loop_mode = 2'h0;
logic [47:0] loop_word = 48'h0, applied_word;
logic phase_locked, freq_locked, history_strobe, history_irq;
logic [15:0] synth_phase, s0;
int num_errors = 0;
int n_checks = 0;
int stamps[$];
// Equal top bits must pass untouched: limits are inclusive
dtw_row_t rows [6] = '{
    '{2'h0, 24'h0, 24'hffffff, LW, FREE}, '{2'h1, 24'h0, 24'hffffff, LW, LW},
    '{2'h1, 24'h0, 24'h0a0000, LW, 48'h0a00_0000_0000},
    '{2'h1, 24'h0b0000, 24'hffffff, LW, 48'h0b00_0000_0000},
    '{2'h0, 24'h0, 24'h100000, LW, 48'h1000_0000_0000},
    '{2'h1, 24'h0a0a00, 24'h0a0a00, LW, LW}};
dtw_path #(.MS_CYCLES(4)) u_dtw_path (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .loop_mode(loop_mode), .switchover(switchover), .new_ref(new_ref),
    .hist_clear_pin(hist_clear_pin), .loop_word(loop_word), .phase_valid(phase_valid),
    .phase_err(phase_err), .freq_valid(freq_valid), .period_diff(period_diff),
    .phase_locked(phase_locked), .freq_locked(freq_locked),
    .history_strobe(history_strobe), .history_irq(history_irq),
    .applied_word(applied_word), .synth_phase(synth_phase));
always #12.5 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        num_errors++;
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
endtask
task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
endtask
task automatic rreg(input logic [11:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    rv = rdata;
endtask
task automatic samp(input logic fq, input logic [31:0] v, input int n);
    repeat (n) begin
        @(posedge mclk);
        phase_valid <= !fq;
        freq_valid <= fq;
        phase_err <= v;
        period_diff <= v;
    end
    @(posedge mclk);
    phase_valid <= 1'b0;
    freq_valid <= 1'b0;
    tick(2);
endtask
task automatic pulse_ref;
    @(posedge mclk);
    new_ref <= 1'b1;
    @(posedge mclk);
    new_ref <= 1'b0;
    tick(2);
endtask
task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    #60us;
    num_errors++;
    finish_test;
end
initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(`DTW_A_CLAMP_LO);
    chk(rv, 48'h0);
    rreg(`DTW_A_CLAMP_HI);
    chk(rv, 48'hffffff);
    rreg(12'h555);
    chk(rv, 48'h0);
    wreg(`DTW_A_HIST_LO, 32'h5a5a5a5a);
    rreg(`DTW_A_HIST_LO);
    chk(rv, 48'h0);
    $display("reset test done");
    wreg(`DTW_A_FREE_LO, FREE[31:0]);
    wreg(`DTW_A_FREE_HI, {16'h0, FREE[47:32]});
    foreach (rows[i]) begin
        wreg(`DTW_A_CLAMP_HI, {8'h0, rows[i].hi});
        wreg(`DTW_A_CLAMP_LO, {8'h0, rows[i].lo});
        loop_mode <= rows[i].mode;
        loop_word <= rows[i].lw;
        tick(4);
        chk(applied_word, rows[i].exp);
    end
    wreg(`DTW_A_CLAMP_LO, 32'h0);
    wreg(`DTW_A_CLAMP_HI, 32'h00ffffff);
    $display("select and clamp test done");
    // Fill 255 from empty: 13 samples pass the upper mark
    wreg(`DTW_A_LOCK_CFG, {8'hff, 8'hff, 16'd100});
    samp(1'b0, 32'hffffff9c, 12);
    chk(phase_locked, 1'b0);
    samp(1'b0, 32'hffffff9c, 1);
    chk(phase_locked, 1'b1);
    samp(1'b0, 32'd0, 10);
    samp(1'b0, 32'd101, 12);
    chk(phase_locked, 1'b1);
    samp(1'b0, 32'd101, 1);
    chk(phase_locked, 1'b0);
    samp(1'b0, 32'd0, 14);
    switchover <= 1'b1;
    loop_mode <= 2'h2;
    tick(4);
    chk(phase_locked, 1'b1);
    switchover <= 1'b0;
    tick(3);
    chk(phase_locked, 1'b0);
    loop_mode <= 2'h1;
    wreg(`DTW_A_FREQ_THR, 32'd300);
    samp(1'b1, 32'hfffffed4, 12);
    chk(freq_locked, 1'b0);
    samp(1'b1, 32'hfffffed4, 1);
    chk(freq_locked, 1'b1);
    $display("lock test done");
    // Interval of 8 cycles, K of one
    loop_mode <= 2'h0;
    loop_word <= LW;
    wreg(`DTW_A_AVG_INT, 32'd2);
    wreg(`DTW_A_HIST_CTL, 32'h01);
    wreg(`DTW_A_IRQ_MASK, 32'h1);
    wreg(`DTW_A_CMD, 32'h4);
    tick(4);
    loop_mode <= 2'h1;
    for (int c = 0; c < 40; c++) begin
        tick(1);
        if (history_strobe === 1'b1) stamps.push_back(c);
    end
    chk(48'(stamps[1] - stamps[0]), 48'd4);
    chk(48'(stamps[2] - stamps[1]), 48'd8);
    chk(48'(stamps[3] - stamps[2]), 48'd8);
    rreg(`DTW_A_HIST_LO);
    chk(rv, {16'h0, LW[31:0]});
    rreg(`DTW_A_HIST_HI);
    chk(rv, {32'h0, LW[47:32]});
    rreg(`DTW_A_STATUS);
    chk(rv[3:2], 2'h3);
    chk(history_irq, 1'b1);
    loop_mode <= 2'h2;
    loop_word <= 48'h0505_0000_0000;
    tick(4);
    chk(applied_word, LW);
    wreg(`DTW_A_STATUS, 32'h4);
    tick(2);
    chk(history_irq, 1'b0);
    wreg(`DTW_A_HIST_CTL, 32'h08);
    pulse_ref;
    rreg(`DTW_A_STATUS);
    chk(rv[3], 1'b1);
    wreg(`DTW_A_HIST_CTL, 32'h00);
    pulse_ref;
    rreg(`DTW_A_STATUS);
    chk(rv[3], 1'b0);
    chk(applied_word, FREE);
    $display("history test done");
    loop_mode <= 2'h0;
    wreg(`DTW_A_FREE_LO, 32'h0);
    wreg(`DTW_A_FREE_HI, 32'h0);
    tick(4);
    s0 = synth_phase;
    wreg(`DTW_A_PHASE_OFS, 32'h1000);
    tick(4);
    chk(synth_phase, 16'(s0 + 16'h1000));
    $display("offset test done");
    finish_test;
end
endmodule // dtw_path_bench
